// ==== logic/radio_modem_config_bank.sv ====
// APB register bank for carrier, rate, deviation and demodulator settings
// assumes APB3 master on I_CLOCK; radio state input synchronous to I_CLOCK
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module radio_modem_config_bank
	import modem_cfg_pkg::*;
(
	input  wire logic         I_CLOCK,
	input  wire logic         I_RESETN,
	input  wire logic         I_PSEL,
	input  wire logic         I_PENABLE,
	input  wire logic         I_PWRITE,
	input  wire logic [11:0]  I_PADDR,
	input  wire logic [31:0]  I_PWDATA,
	input  wire radio_state_t I_RADIO_STATE,
	output logic [31:0]       O_PRDATA,
	output logic              O_PREADY,
	output logic              O_PSLVERR,
	output logic [23:0]       O_CARRIER_WORD,
	output logic [11:0]       O_BIT_RATE_WORD,
	output logic [11:0]       O_TONE_OFFSET_WORD,
	output logic [7:0]        O_CORRELATOR_BANDWIDTH,
	output logic [7:0]        O_POST_FILTER_BANDWIDTH,
	output logic [5:0]        O_RX_LOOP_TUNE,
	output logic [1:0]        O_CORRELATOR_PHASE,
	output logic [1:0]        O_LOOP_TABLE_SELECT,
	output logic              O_LOAD_TX_TABLE,
	output logic              O_LOAD_RX_TABLE
);
	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
		logic [31:0]              rdata;
		logic                     ready;
		logic                     slverr;
		logic [23:0]              carrier;
		logic [11:0]              rate;
		logic [11:0]              dev;
		logic [7:0]               corr_bw;
		logic [7:0]               post_bw;
		logic [5:0]               tune;
		logic [1:0]               phase;
		logic [1:0]               sel;
	} bank_t;

	bank_t st;
	bank_t next_st;
	logic  rst_meta;
	logic  rst_sync;
	logic  load_tx;
	logic  load_rx;
	logic  load_tx_q;
	logic  load_rx_q;

	// byte address is four times the index; returns index slot or -1
	function automatic int reg_slot(input logic [11:0] addr);
		reg_slot = -1;
		if (addr[1:0] != 2'h0) begin
			reg_slot = -1;
		end else if (addr[11:2] >= IDX_CARRIER_LOW && addr[11:2] <= IDX_LOOP_SELECT) begin
			reg_slot = int'(addr[11:2] - IDX_CARRIER_LOW);
		end
	endfunction

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	always_comb begin
		int slot;
		slot = reg_slot(I_PADDR);
		next_st = st;
		next_st.ready = 1'b0;
		next_st.slverr = 1'b0;
		// one wait state: answer on the second access-phase edge
		if (I_PSEL && I_PENABLE && !st.ready) begin
			next_st.ready = 1'b1;
			if (slot < 0) begin
				next_st.slverr = 1'b1;
				next_st.rdata = 32'h0000_0000;
			end else if (!I_PWRITE) begin
				next_st.rdata = {24'h00_0000, st.regs[slot]};
			end
		end
		// write lands only at the completing edge
		if (I_PSEL && I_PENABLE && st.ready && I_PWRITE && slot >= 0) begin
			next_st.regs[slot] = I_PWDATA[7:0];
		end
		next_st.carrier = {next_st.regs[IDX_CARRIER_HIGH - IDX_CARRIER_LOW],
			next_st.regs[IDX_CARRIER_MID - IDX_CARRIER_LOW],
			next_st.regs[0]};
		next_st.rate = {next_st.regs[IDX_RATE_DEV_HIGH - IDX_CARRIER_LOW][RATE_HI_LSB +: 4],
			next_st.regs[IDX_BIT_RATE_LOW - IDX_CARRIER_LOW]};
		next_st.dev = {next_st.regs[IDX_RATE_DEV_HIGH - IDX_CARRIER_LOW][DEV_HI_LSB +: 4],
			next_st.regs[IDX_DEV_LOW - IDX_CARRIER_LOW]};
		next_st.corr_bw = next_st.regs[IDX_CORR_BW - IDX_CARRIER_LOW];
		// bandwidth code passed on; synthesizer doubles it
		next_st.post_bw = next_st.regs[IDX_POST_BW - IDX_CARRIER_LOW];
		next_st.sel = next_st.regs[IDX_LOOP_SELECT - IDX_CARRIER_LOW][SELECT_LSB +: 2];
		// tuning only honoured for select 1 or 3
		next_st.tune = next_st.sel[0] ? next_st.regs[IDX_LOOP_TUNE - IDX_CARRIER_LOW][TUNE_LSB +: 6] : 6'h00;
		next_st.phase = next_st.regs[IDX_LOOP_TUNE - IDX_CARRIER_LOW][PHASE_LSB +: 2];
	end

	always_ff @(posedge I_CLOCK or negedge rst_sync) begin
		if (!rst_sync) begin
			st <= '0;
			load_tx_q <= 1'b0;
			load_rx_q <= 1'b0;
		end else begin
			st <= next_st;
			load_tx_q <= load_tx;
			load_rx_q <= load_rx;
		end
	end

	loop_table_loader u_loader (
		.i_clock       (I_CLOCK),
		.i_resetn      (rst_sync),
		.i_radio_state (I_RADIO_STATE),
		.i_select      (st.sel),
		.o_load_tx     (load_tx),
		.o_load_rx     (load_rx)
	);

	assign O_PRDATA = st.rdata;
	assign O_PREADY = st.ready;
	assign O_PSLVERR = st.slverr;
	assign O_CARRIER_WORD = st.carrier;
	assign O_BIT_RATE_WORD = st.rate;
	assign O_TONE_OFFSET_WORD = st.dev;
	assign O_CORRELATOR_BANDWIDTH = st.corr_bw;
	assign O_POST_FILTER_BANDWIDTH = st.post_bw;
	assign O_RX_LOOP_TUNE = st.tune;
	assign O_CORRELATOR_PHASE = st.phase;
	assign O_LOOP_TABLE_SELECT = st.sel;
	assign O_LOAD_TX_TABLE = load_tx_q;
	assign O_LOAD_RX_TABLE = load_rx_q;
endmodule

// ==== logic/modem_cfg_pkg.sv ====
// constants and register map of the modem configuration bank
// assumes a 40 MHz system clock and an APB master with 32-bit data
package modem_cfg_pkg;
	// printed offsets are not multiples of four: they are register indices
	localparam logic [9:0] IDX_CARRIER_LOW   = 10'h109;
	localparam logic [9:0] IDX_CARRIER_MID   = 10'h10a;
	localparam logic [9:0] IDX_CARRIER_HIGH  = 10'h10b;
	localparam logic [9:0] IDX_BIT_RATE_LOW  = 10'h10c;
	localparam logic [9:0] IDX_RATE_DEV_HIGH = 10'h10d;
	localparam logic [9:0] IDX_DEV_LOW       = 10'h10e;
	localparam logic [9:0] IDX_CORR_BW       = 10'h10f;
	localparam logic [9:0] IDX_POST_BW       = 10'h110;
	localparam logic [9:0] IDX_SPARE         = 10'h111;
	localparam logic [9:0] IDX_LOOP_TUNE     = 10'h112;
	localparam logic [9:0] IDX_LOOP_SELECT   = 10'h113;
	localparam int         NUM_REGS          = 11;
	localparam logic [7:0] REG_RESET         = 8'h00;
	// field positions
	localparam int RATE_HI_LSB  = 0;
	localparam int DEV_HI_LSB   = 4;
	localparam int PHASE_LSB    = 0;
	localparam int TUNE_LSB     = 2;
	localparam int SELECT_LSB   = 4;
	// comparison frequency and scale factors
	localparam longint COMPARISON_FREQ_HZ = 64'd26000000;
	localparam int     FRAC_BITS          = 16;
	localparam int     RATE_STEP          = 100;
	localparam int     DEV_STEP           = 100;
	localparam int     POST_BW_MULT       = 2;
	localparam logic [1:0] SEL_AUTO       = 2'h0;
	typedef enum logic [1:0] {
		RADIO_IDLE = 2'b00,
		RADIO_RX   = 2'b01,
		RADIO_TX   = 2'b10
	} radio_state_t;
endpackage

// ==== logic/loop_table_loader.sv ====
// loads predefined loop bandwidth tables when the radio enters rx or tx while the table select is auto (0)
// assumes the radio state input is synchronous to the system clock
`timescale 1ns/10ps
module loop_table_loader
	import modem_cfg_pkg::*;
(
	input  wire logic         i_clock,
	input  wire logic         i_resetn,
	input  wire radio_state_t i_radio_state,
	input  wire logic [1:0]   i_select,
	output logic              o_load_tx,
	output logic              o_load_rx
);
	typedef struct packed {
		radio_state_t prev;
		logic         load_tx;
		logic         load_rx;
	} loader_t;
	loader_t st;
	loader_t next_st;

	always_comb begin
		next_st = st;
		next_st.prev = i_radio_state;
		next_st.load_tx = (i_select == SEL_AUTO) && (i_radio_state == RADIO_TX) && (st.prev != RADIO_TX);
		next_st.load_rx = (i_select == SEL_AUTO) && (i_radio_state == RADIO_RX) && (st.prev != RADIO_RX);
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= '{prev: RADIO_IDLE, load_tx: 1'b0, load_rx: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign o_load_tx = st.load_tx;
	assign o_load_rx = st.load_rx;
endmodule

// ==== bench/radio_modem_config_bank_props.sv ====
// port checker for the modem configuration bank
// assumes it is bound onto radio_modem_config_bank, one clock domain
`timescale 1ns/10ps
module radio_modem_config_bank_chk
	import modem_cfg_pkg::*;
(
	input wire logic         I_CLOCK,
	input wire logic         I_RESETN,
	input wire logic         I_PSEL,
	input wire logic         I_PENABLE,
	input wire logic         I_PWRITE,
	input wire logic [11:0]  I_PADDR,
	input wire logic [31:0]  I_PWDATA,
	input wire radio_state_t I_RADIO_STATE,
	input wire logic [31:0]  O_PRDATA,
	input wire logic         O_PREADY,
	input wire logic         O_PSLVERR,
	input wire logic [23:0]  O_CARRIER_WORD,
	input wire logic [7:0]   O_POST_FILTER_BANDWIDTH,
	input wire logic [5:0]   O_RX_LOOP_TUNE,
	input wire logic [1:0]   O_LOOP_TABLE_SELECT,
	input wire logic         O_LOAD_TX_TABLE,
	input wire logic         O_LOAD_RX_TABLE
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);
	logic wr;
	assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && !O_PSLVERR;
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("pready held");
	a_err_zero: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0) else $error("bad refusal");
	a_carrier_low: assert property (wr && I_PADDR == {IDX_CARRIER_LOW, 2'b00} |=>
		O_CARRIER_WORD[7:0] == $past(I_PWDATA[7:0])) else $error("carrier low byte");
	a_carrier_high: assert property (wr && I_PADDR == {IDX_CARRIER_HIGH, 2'b00} |=>
		O_CARRIER_WORD[23:16] == $past(I_PWDATA[7:0])) else $error("carrier high byte");
	a_post_bw: assert property (wr && I_PADDR == {IDX_POST_BW, 2'b00} |=>
		O_POST_FILTER_BANDWIDTH == $past(I_PWDATA[7:0])) else $error("post filter width");
	a_tune_gate: assert property (!O_LOOP_TABLE_SELECT[0] |-> O_RX_LOOP_TUNE == 6'h0) else $error("tune open");
	a_carrier_hold: assert property (!wr |=> $stable(O_CARRIER_WORD)) else $error("carrier moved");
	a_load_rx: assert property (I_RADIO_STATE == RADIO_RX && $past(I_RADIO_STATE) != RADIO_RX &&
		O_LOOP_TABLE_SELECT == SEL_AUTO |-> ##[1:3] O_LOAD_RX_TABLE) else $error("no rx table load");
	a_load_tx: assert property (I_RADIO_STATE == RADIO_TX && $past(I_RADIO_STATE) != RADIO_TX &&
		O_LOOP_TABLE_SELECT == SEL_AUTO |-> ##[1:3] O_LOAD_TX_TABLE) else $error("no tx table load");
	a_load_cause: assert property (O_LOAD_RX_TABLE |-> $past(O_LOOP_TABLE_SELECT, 2) == SEL_AUTO &&
		$past(I_RADIO_STATE, 2) == RADIO_RX) else $error("rx table load without cause");
endmodule
bind radio_modem_config_bank radio_modem_config_bank_chk u_chk (.I_CLOCK, .I_RESETN, .I_PSEL, .I_PENABLE,
	.I_PWRITE, .I_PADDR, .I_PWDATA, .I_RADIO_STATE, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_CARRIER_WORD,
	.O_POST_FILTER_BANDWIDTH, .O_RX_LOOP_TUNE, .O_LOOP_TABLE_SELECT, .O_LOAD_TX_TABLE, .O_LOAD_RX_TABLE);

// ==== bench/test_radio_modem_config_bank.sv ====
// bench for the modem configuration bank
// drives APB and radio state itself, checks ports directly
`timescale 1ns/10ps
module test_radio_modem_config_bank
	import modem_cfg_pkg::*;
;
	logic         clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, e, ltx, lrx, pready, perr, got;
	logic [11:0]  addr = 0;
	logic [31:0]  wdata = 0, q, prdata;
	radio_state_t st = RADIO_IDLE;
	logic [23:0]  cw;
	logic [11:0]  br, tw;
	logic [7:0]   cb, pb;
	logic [5:0]   tune;
	logic [1:0]   ph, sel;
	logic [7:0]   v [11] = '{8'h56, 8'h34, 8'h12, 8'hab, 8'hc5, 8'h9e, 8'ha5, 8'h36, 8'h00, 8'hb7, 8'h30};
	int           err_count = 0, compares = 0, cycles = 0;
	always #12.5 clk = ~clk;
	radio_modem_config_bank dut (.I_CLOCK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(addr), .I_PWDATA(wdata), .I_RADIO_STATE(st), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(perr), .O_CARRIER_WORD(cw), .O_BIT_RATE_WORD(br), .O_TONE_OFFSET_WORD(tw),
		.O_CORRELATOR_BANDWIDTH(cb), .O_POST_FILTER_BANDWIDTH(pb), .O_RX_LOOP_TUNE(tune),
		.O_CORRELATOR_PHASE(ph), .O_LOOP_TABLE_SELECT(sel), .O_LOAD_TX_TABLE(ltx), .O_LOAD_RX_TABLE(lrx));
	// pready read just after the edge is its value at that edge, before the flops move
	task automatic apb(input logic w, input logic [9:0] idx, input logic [1:0] off, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= {idx, off};
		wdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && n++ < 40);
		q = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (pready !== 1'b1) begin
			$display("ERROR pready expected 1 seen %b", pready);
			err_count++;
		end
		// outputs launched at the completing edge are settled by the falling edge
		@(negedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", nm, x, g);
			err_count++;
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			$display("ERROR timeout expected done seen %0d cycles", cycles);
			err_count++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < NUM_REGS; i++) begin
			apb(1'b0, 10'(IDX_CARRIER_LOW + i), 2'h0, 8'h0);
			chk("reset value", {24'h0, REG_RESET}, q);
		end
		// spare byte gets zero; post filter 0x36 is 108 kHz, near 0.75 of 145.1 kbps
		for (int i = 0; i < NUM_REGS; i++) apb(1'b1, 10'(IDX_CARRIER_LOW + i), 2'h0, v[i]);
		for (int i = 0; i < NUM_REGS; i++) begin
			apb(1'b0, 10'(IDX_CARRIER_LOW + i), 2'h0, 8'h0);
			chk("readback", {24'h0, v[i]}, q);
		end
		chk("carrier", 32'h123456, {8'h0, cw});
		chk("bit rate", 32'h5ab, {20'h0, br});
		chk("deviation", 32'hc9e, {20'h0, tw});
		chk("correlator bw", 32'ha5, {24'h0, cb});
		chk("post bw", 32'h36, {24'h0, pb});
		chk("phase", 32'h3, {30'h0, ph});
		for (int s = 3; s >= 0; s--) begin
			apb(1'b1, IDX_LOOP_SELECT, 2'h0, 8'(s << SELECT_LSB));
			chk("select", 32'(s), {30'h0, sel});
			chk("loop tune", s[0] ? 32'h2d : 32'h0, {26'h0, tune});
		end
		apb(1'b1, 10'h114, 2'h0, 8'h77);
		chk("unmapped err", 32'h1, {31'h0, e});
		apb(1'b1, IDX_CARRIER_LOW, 2'h1, 8'h77);
		chk("misaligned err", 32'h1, {31'h0, e});
		chk("carrier kept", 32'h123456, {8'h0, cw});
		for (int k = 1; k <= 2; k++) begin
			@(posedge clk);
			st <= radio_state_t'(k);
			got = 1'b0;
			repeat (6) begin
				@(negedge clk);
				got |= ((k == 1 ? lrx : ltx) === 1'b1);
			end
			chk("table load", 32'h1, {31'h0, got});
			@(posedge clk);
			st <= RADIO_IDLE;
		end
		// custom table select: entering rx must not load the tables
		apb(1'b1, IDX_LOOP_SELECT, 2'h0, 8'h10);
		@(posedge clk);
		st <= RADIO_RX;
		got = 1'b0;
		repeat (6) begin
			@(negedge clk);
			got |= (lrx !== 1'b0);
		end
		chk("no table load", 32'h0, {31'h0, got});
		final_report();
	end
endmodule
